// >>> pkg/option_cfg_pkg.sv
// Constants, field positions and state types of the option byte decoder.
// Summary of operation
// [R1] An erased option store reads FFh in each byte, so every option defaults to 1.
// [R2] The option bytes have no address and can be read or written only in programming mode.
// [R3] Byte 0 bit 7 set makes entering halt with the watchdog active cause a reset; clear means no reset.
// [R4] Byte 0 bit 6 clear gives a hardware watchdog that is always on; set leaves enabling to software.
// [R5] Byte 0 bit 5 clear selects the PLL as system clock; set selects the oscillator.
// [R6] Byte 0 bits 4:3 code 00 enables both voltage detectors, 01 only the low-voltage one, 10 neither.
// [R7] Voltage code 11 disables both detectors, the same as code 10.
// [R8] Byte 0 bit 2 clear gives a 4096-cycle reset and halt-exit phase; set gives 256 cycles.
// [R9] With the PLL selected the reset phase is always 4096 cycles, whatever bit 2 holds.
// [R10] The programmer should pick the 4096-cycle phase when a crystal or resonator is fitted.
// [R11] Byte 0 bit 1 clear enables the divide-by-two stage feeding the PLL; set bypasses it.
// [R12] Byte 0 bit 0 clear blocks user memory access in test and in-circuit programming modes.
// [R13] Erasing the options while protection is on first erases the whole user memory.
// [R14] Byte 1 bits 7:5 select the package: 000 32, 001 44, 010 56, 011 64, 1xx 80 pins.
// [R15] Byte 1 bits 1:0 set the motor outputs in reset: 01 low, 10 high, 00 and 11 high impedance.
// [R16] Both bytes are loaded during reset and the settings hold until the next reset.
package option_cfg_pkg;

  localparam int          OPT_BYTES         = 2;
  localparam logic [7:0]  OPT_ERASED        = 8'hFF;
  localparam logic [7:0]  RDATA_IDLE        = 8'h00;

  // Byte 0 field positions.
  localparam int          B0_HALT_RST       = 7;
  localparam int          B0_WATCHDOG_TYPE_SELECT         = 6;
  localparam int          B0_CLK_SRC        = 5;
  localparam int          B0_VD_HI          = 4;
  localparam int          B0_VD_LO          = 3;
  localparam int          B0_RST_LEN        = 2;
  localparam int          B0_HALF_CLOCK_DIVIDER           = 1;
  localparam int          B0_PROTECT        = 0;

  // Byte 1 field positions.
  localparam int          B1_PKG_HI         = 7;
  localparam int          B1_PKG_MID        = 6;
  localparam int          B1_PKG_LO         = 5;
  localparam int          B1_MCO_HI         = 1;
  localparam int          B1_MCO_LO         = 0;

  localparam logic [1:0]  VD_BOTH_ON        = 2'h0;
  localparam logic [1:0]  VD_LOW_ONLY       = 2'h1;
  localparam logic [1:0]  MCO_DRIVE_LOW     = 2'h1;
  localparam logic [1:0]  MCO_DRIVE_HIGH    = 2'h2;

  localparam logic [2:0]  PKG_32            = 3'h0;
  localparam logic [2:0]  PKG_44            = 3'h1;
  localparam logic [2:0]  PKG_56            = 3'h2;
  localparam logic [6:0]  PINS_32           = 7'h20;
  localparam logic [6:0]  PINS_44           = 7'h2C;
  localparam logic [6:0]  PINS_56           = 7'h38;
  localparam logic [6:0]  PINS_64           = 7'h40;
  localparam logic [6:0]  PINS_80           = 7'h50;

  localparam logic [12:0] RESET_LONG_CYCLES  = 13'h1000;
  localparam logic [12:0] RESET_SHORT_CYCLES = 13'h0100;

  // Positions inside the synchronised programming pin vector.
  localparam int          PIN_W             = 12;
  localparam int          PIN_MODE          = 11;
  localparam int          PIN_SEL           = 10;
  localparam int          PIN_WR            = 9;
  localparam int          PIN_ERASE         = 8;

  typedef enum logic [1:0] {
    ST_LOAD,
    ST_RUN,
    ST_ERASE_USER
  } cfg_state_t;

endpackage

// >>> core/option_store.sv
// Non-volatile option byte store held in flip-flops.
module option_store (
  // Clock and power-up clear
  input  wire logic       clk,
  input  wire logic       store_init,
  // Programming access
  input  wire logic       wr,
  input  wire logic       idx,
  input  wire logic [7:0] wdata,
  input  wire logic       erase,
  // Contents
  output logic      [7:0] byte0,
  output logic      [7:0] byte1
);

  logic [7:0] mem [option_cfg_pkg::OPT_BYTES];

  // Only the power-up clear touches the store; the system reset must not,
  // otherwise the options would be lost on every reset.
  generate
    for (genvar i = 0; i < option_cfg_pkg::OPT_BYTES; i++) begin : g_byte
      always_ff @(posedge clk or posedge store_init) begin
        if (store_init) begin
          mem[i] <= option_cfg_pkg::OPT_ERASED; // R1
        end else if (erase) begin
          mem[i] <= option_cfg_pkg::OPT_ERASED; // R1
        end else if (wr && (int'(idx) == i)) begin
          mem[i] <= wdata;
        end
      end
    end
  endgenerate

  assign byte0 = mem[0];
  assign byte1 = mem[1];

endmodule

// >>> core/option_byte_config_decoder.sv
// Option byte loader and decoder that drives the static hardware settings.
module option_byte_config_decoder (
  // Clock and resets
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        store_init,
  // Programming pins from the external tool
  input  wire logic        prog_mode,
  input  wire logic        prog_sel,
  input  wire logic        prog_wr,
  input  wire logic        prog_erase,
  input  wire logic [7:0]  prog_wdata,
  output logic      [7:0]  prog_rdata,
  output logic             prog_busy,
  // User memory erase handshake and access block
  output logic             user_erase_req,
  input  wire logic        user_erase_done,
  output logic             user_mem_block,
  // Watchdog settings
  output logic             halt_entry_reset_select,
  output logic             watchdog_type_select,
  // Clock and reset settings
  output logic             clock_source_select,
  output logic             half_clock_divider,
  output logic      [12:0] reset_cycles,
  // Supervisor settings
  output logic             low_voltage_detector,
  output logic             auxiliary_voltage_detector,
  // Protection, package and motor output settings
  output logic             readout_protect,
  output logic      [2:0]  package_code,
  output logic      [6:0]  package_pins,
  output logic             motor_output_reset_oe,
  output logic             motor_output_reset_level
);

  option_cfg_pkg::cfg_state_t state;

  logic [option_cfg_pkg::PIN_W-1:0] pin_meta;
  logic [option_cfg_pkg::PIN_W-1:0] pin_sync;
  logic [option_cfg_pkg::PIN_W-1:0] pin_prev;
  logic                             mode_s;
  logic                             wr_pulse;
  logic                             erase_pulse;
  logic                             store_wr;
  logic                             store_erase;
  logic                             store_idx;
  logic [7:0]                       store_wdata;
  logic [7:0]                       store_b0;
  logic [7:0]                       store_b1;
  logic [7:0]                       cfg0;
  logic [7:0]                       cfg1;
  logic [1:0]                       vd_code;
  logic [1:0]                       mco_code;

  // The tool's pins are asynchronous; the first stage is read only here.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= {prog_mode, prog_sel, prog_wr, prog_erase, prog_wdata};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign mode_s      = pin_sync[option_cfg_pkg::PIN_MODE];
  assign wr_pulse    = pin_sync[option_cfg_pkg::PIN_WR] &&
                       !pin_prev[option_cfg_pkg::PIN_WR];
  assign erase_pulse = pin_sync[option_cfg_pkg::PIN_ERASE] &&
                       !pin_prev[option_cfg_pkg::PIN_ERASE];

  option_store u_store (
    .clk        (clk),
    .store_init (store_init),
    .wr         (store_wr),
    .idx        (store_idx),
    .wdata      (store_wdata),
    .erase      (store_erase),
    .byte0      (store_b0),
    .byte1      (store_b1)
  );

  // Sequencer: one load cycle after reset, then programming service.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= option_cfg_pkg::ST_LOAD;
    end else begin
      case (state)
        option_cfg_pkg::ST_LOAD: begin
          state <= option_cfg_pkg::ST_RUN; // R16
        end
        option_cfg_pkg::ST_RUN: begin
          if (erase_pulse && mode_s &&
              !store_b0[option_cfg_pkg::B0_PROTECT]) begin
            state <= option_cfg_pkg::ST_ERASE_USER; // R13
          end
        end
        option_cfg_pkg::ST_ERASE_USER: begin
          if (user_erase_done) begin
            state <= option_cfg_pkg::ST_RUN;
          end
        end
        default: begin
          state <= option_cfg_pkg::ST_LOAD;
        end
      endcase
    end
  end

  // Store access: strobes act only in programming mode; the deferred erase follows user_erase_done in any mode.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      store_wr    <= 1'b0;
      store_erase <= 1'b0;
      store_idx   <= 1'b0;
      store_wdata <= option_cfg_pkg::OPT_ERASED;
    end else begin
      store_wr    <= 1'b0;
      store_erase <= 1'b0;
      if (state == option_cfg_pkg::ST_RUN && mode_s) begin // R2
        if (erase_pulse) begin
          store_erase <= store_b0[option_cfg_pkg::B0_PROTECT]; // R13
        end else if (wr_pulse) begin
          store_wr    <= 1'b1;
          store_idx   <= pin_sync[option_cfg_pkg::PIN_SEL];
          store_wdata <= pin_sync[7:0];
        end
      end else if (state == option_cfg_pkg::ST_ERASE_USER &&
                   user_erase_done) begin
        store_erase <= 1'b1; // R13
      end
    end
  end

  // User memory erase request stands until the memory reports done.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      user_erase_req <= 1'b0;
    end else begin
      user_erase_req <= (state == option_cfg_pkg::ST_RUN && erase_pulse &&
                         mode_s && !store_b0[option_cfg_pkg::B0_PROTECT]) ||
                        (state == option_cfg_pkg::ST_ERASE_USER &&
                         !user_erase_done); // R13
    end
  end

  // Readback and status toward the tool.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_rdata <= option_cfg_pkg::RDATA_IDLE;
      prog_busy  <= 1'b1;
    end else begin
      if (mode_s) begin // R2
        prog_rdata <= pin_sync[option_cfg_pkg::PIN_SEL] ? store_b1 : store_b0;
      end else begin
        prog_rdata <= option_cfg_pkg::RDATA_IDLE;
      end
      prog_busy <= (state != option_cfg_pkg::ST_RUN);
    end
  end

  // Protection blocks user memory whenever a programming mode is entered.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      user_mem_block <= 1'b0;
    end else begin
      user_mem_block <= mode_s && readout_protect; // R12
    end
  end

  // Snapshot of both bytes taken once per reset; later programming only
  // changes the store, so new options apply at the next reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg0 <= option_cfg_pkg::OPT_ERASED;
      cfg1 <= option_cfg_pkg::OPT_ERASED;
    end else if (state == option_cfg_pkg::ST_LOAD) begin
      cfg0 <= store_b0; // R16
      cfg1 <= store_b1; // R16
    end
  end

  assign vd_code  = {store_b0[option_cfg_pkg::B0_VD_HI],
                     store_b0[option_cfg_pkg::B0_VD_LO]};
  assign mco_code = {store_b1[option_cfg_pkg::B1_MCO_HI],
                     store_b1[option_cfg_pkg::B1_MCO_LO]};

  // Decoded settings, loaded in the same cycle as the snapshot. Reset
  // values are those of an erased store.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halt_entry_reset_select    <= 1'b1;
      watchdog_type_select       <= 1'b1;
      clock_source_select        <= 1'b1;
      half_clock_divider         <= 1'b0;
      reset_cycles               <= option_cfg_pkg::RESET_SHORT_CYCLES;
      low_voltage_detector       <= 1'b0;
      auxiliary_voltage_detector <= 1'b0;
      readout_protect            <= 1'b0;
      package_code               <= 3'h7;
      package_pins               <= option_cfg_pkg::PINS_80;
      motor_output_reset_oe      <= 1'b0;
      motor_output_reset_level   <= 1'b0;
    end else if (state == option_cfg_pkg::ST_LOAD) begin
      halt_entry_reset_select <= store_b0[option_cfg_pkg::B0_HALT_RST]; // R3
      watchdog_type_select    <= store_b0[option_cfg_pkg::B0_WATCHDOG_TYPE_SELECT]; // R4
      clock_source_select     <= store_b0[option_cfg_pkg::B0_CLK_SRC]; // R5
      half_clock_divider      <= !store_b0[option_cfg_pkg::B0_HALF_CLOCK_DIVIDER]; // R11
      // PLL selection overrides a short reset phase.
      if (store_b0[option_cfg_pkg::B0_CLK_SRC] &&
          store_b0[option_cfg_pkg::B0_RST_LEN]) begin
        reset_cycles <= option_cfg_pkg::RESET_SHORT_CYCLES; // R8
      end else begin
        reset_cycles <= option_cfg_pkg::RESET_LONG_CYCLES; // R9
      end
      low_voltage_detector <= (vd_code == option_cfg_pkg::VD_BOTH_ON) ||
                              (vd_code == option_cfg_pkg::VD_LOW_ONLY); // R6
      auxiliary_voltage_detector <=
        (vd_code == option_cfg_pkg::VD_BOTH_ON); // R7
      readout_protect <= !store_b0[option_cfg_pkg::B0_PROTECT]; // R12
      package_code <= {store_b1[option_cfg_pkg::B1_PKG_HI],
                       store_b1[option_cfg_pkg::B1_PKG_MID],
                       store_b1[option_cfg_pkg::B1_PKG_LO]};
      if (store_b1[option_cfg_pkg::B1_PKG_HI]) begin
        package_pins <= option_cfg_pkg::PINS_80; // R14
      end else begin
        case ({store_b1[option_cfg_pkg::B1_PKG_MID],
               store_b1[option_cfg_pkg::B1_PKG_LO]})
          option_cfg_pkg::PKG_32[1:0]: package_pins <= option_cfg_pkg::PINS_32;
          option_cfg_pkg::PKG_44[1:0]: package_pins <= option_cfg_pkg::PINS_44;
          option_cfg_pkg::PKG_56[1:0]: package_pins <= option_cfg_pkg::PINS_56;
          default:                     package_pins <= option_cfg_pkg::PINS_64;
        endcase
      end
      motor_output_reset_oe <= (mco_code == option_cfg_pkg::MCO_DRIVE_LOW) ||
                               (mco_code == option_cfg_pkg::MCO_DRIVE_HIGH);
      motor_output_reset_level <=
        (mco_code == option_cfg_pkg::MCO_DRIVE_HIGH); // R15
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence protected_erase_s;
    state == option_cfg_pkg::ST_RUN && erase_pulse && mode_s &&
    !store_b0[option_cfg_pkg::B0_PROTECT];
  endsequence

  sequence user_done_s;
    state == option_cfg_pkg::ST_ERASE_USER && user_erase_done;
  endsequence

  AST_ERASED_READS_FF: assert property ( // R1
    store_erase |=> store_b0 == option_cfg_pkg::OPT_ERASED &&
                    store_b1 == option_cfg_pkg::OPT_ERASED)
    else $error("Erased store does not read all ones.");

  AST_WRITE_NEEDS_MODE: assert property ( // R2
    store_wr |-> $past(mode_s))
    else $error("Option store written outside programming mode.");

  AST_HALT_RESET: assert property ( // R3
    state != option_cfg_pkg::ST_LOAD |->
      halt_entry_reset_select == cfg0[option_cfg_pkg::B0_HALT_RST])
    else $error("Halt reset selection differs from loaded byte.");

  AST_WDG_TYPE: assert property ( // R4
    state != option_cfg_pkg::ST_LOAD |->
      watchdog_type_select == cfg0[option_cfg_pkg::B0_WATCHDOG_TYPE_SELECT])
    else $error("Watchdog type differs from loaded byte.");

  AST_CLK_SRC: assert property ( // R5
    state != option_cfg_pkg::ST_LOAD |->
      clock_source_select == cfg0[option_cfg_pkg::B0_CLK_SRC])
    else $error("Clock source differs from loaded byte.");

  AST_VD_BOTH_ON: assert property ( // R6
    state != option_cfg_pkg::ST_LOAD && !cfg0[option_cfg_pkg::B0_VD_HI] |->
      low_voltage_detector &&
      auxiliary_voltage_detector == !cfg0[option_cfg_pkg::B0_VD_LO])
    else $error("Voltage detector enables wrong for code 0x.");

  AST_VD_OFF: assert property ( // R7
    state != option_cfg_pkg::ST_LOAD && cfg0[option_cfg_pkg::B0_VD_HI] |->
      !low_voltage_detector && !auxiliary_voltage_detector)
    else $error("Voltage detectors enabled for code 1x.");

  AST_RESET_LEN: assert property ( // R8
    state != option_cfg_pkg::ST_LOAD && cfg0[option_cfg_pkg::B0_CLK_SRC] |->
      reset_cycles == (cfg0[option_cfg_pkg::B0_RST_LEN] ?
        option_cfg_pkg::RESET_SHORT_CYCLES :
        option_cfg_pkg::RESET_LONG_CYCLES))
    else $error("Reset phase length does not follow its option.");

  AST_PLL_LONG_RESET: assert property ( // R9
    state != option_cfg_pkg::ST_LOAD && !clock_source_select |->
      reset_cycles == option_cfg_pkg::RESET_LONG_CYCLES)
    else $error("PLL selected without the long reset phase.");

  AST_HALF_CLOCK_DIVIDER: assert property ( // R11
    state != option_cfg_pkg::ST_LOAD |->
      half_clock_divider != cfg0[option_cfg_pkg::B0_HALF_CLOCK_DIVIDER])
    else $error("Divider enable has the wrong sense.");

  AST_MEM_BLOCK: assert property ( // R12
    mode_s && readout_protect |=> user_mem_block)
    else $error("Protected memory not blocked in programming mode.");

  AST_ERASE_USER_FIRST: assert property ( // R13
    protected_erase_s |=> user_erase_req && !store_erase)
    else $error("Protected erase did not erase user memory first.");

  AST_ERASE_AFTER_DONE: assert property ( // R13
    user_done_s |=> store_erase ##1
      store_b0 == option_cfg_pkg::OPT_ERASED)
    else $error("Options not erased after user memory erase.");

  AST_PKG_80: assert property ( // R14
    state != option_cfg_pkg::ST_LOAD && cfg1[option_cfg_pkg::B1_PKG_HI] |->
      package_pins == option_cfg_pkg::PINS_80)
    else $error("Package code 1xx does not give 80 pins.");

  AST_MCO_LOW: assert property ( // R15
    state != option_cfg_pkg::ST_LOAD &&
    cfg1[1:0] == option_cfg_pkg::MCO_DRIVE_LOW |->
      motor_output_reset_oe && !motor_output_reset_level)
    else $error("Motor output reset state not driven low.");

  AST_SETTINGS_HELD: assert property ( // R16
    state != option_cfg_pkg::ST_LOAD |=>
      $stable(cfg0) && $stable(cfg1) && $stable(reset_cycles))
    else $error("Settings changed between resets.");

endmodule

// >>> test/prog_tool_model.sv
// Programming tool model that drives the option store pins.
module prog_tool_model (
  // Clock
  input  wire logic       clk,
  // Programming pins
  output logic            prog_mode,
  output logic            prog_sel,
  output logic            prog_wr,
  output logic            prog_erase,
  output logic      [7:0] prog_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    prog_mode  = 1'b0;
    prog_sel   = 1'b0;
    prog_wr    = 1'b0;
    prog_erase = 1'b0;
    prog_wdata = 8'h5A;
  end

  // A board with a resonator keeps the long reset phase.
  function automatic logic [7:0] resonator_image(input logic [7:0] b0);
    return b0 & 8'hFB;
  endfunction

  // Mode passes two sync flops, so strobes wait until it has settled.
  task automatic set_mode(input logic m);
    @(posedge clk);
    prog_mode <= m;
    repeat (4) @(posedge clk);
  endtask

  // One strobe, write or erase, high four cycles and then low as long, so
  // the synchronised edge detector sees exactly one rise per call.
  task automatic pulse(input logic is_erase);
    @(posedge clk);
    prog_wr    <= !is_erase;
    prog_erase <= is_erase;
    repeat (4) @(posedge clk);
    prog_wr    <= 1'b0;
    prog_erase <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Data stays well past the strobe, then flips so no stale byte lingers.
  task automatic write_byte(input logic sel, input logic [7:0] data);
    @(posedge clk);
    prog_sel   <= sel;
    prog_wdata <= data;
    pulse(1'b0);
    prog_wdata <= ~data;
  endtask

  task automatic erase_opts();
    pulse(1'b1);
  endtask
endmodule

// >>> test/option_byte_config_decoder_tb_top.sv
// Self-checking testbench of the option byte decoder.
module option_byte_config_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        store_init = 1'b1;
  logic        user_erase_done = 1'b0;
  logic        prog_mode, prog_sel, prog_wr, prog_erase;
  logic [7:0]  prog_wdata, prog_rdata;
  logic        prog_busy, user_erase_req, user_mem_block;
  logic        halt_entry_reset_select, watchdog_type_select;
  logic        clock_source_select, half_clock_divider;
  logic [12:0] reset_cycles;
  logic        low_voltage_detector, auxiliary_voltage_detector;
  logic        readout_protect, motor_output_reset_oe;
  logic        motor_output_reset_level;
  logic [2:0]  package_code;
  logic [6:0]  package_pins;
  logic [31:0] settings;
  logic [31:0] cur_exp;
  int          err_total = 0;
  int          total_checks = 0;
  logic [7:0]  tb0 [5] = '{8'hAC, 8'h73, 8'hDF, 8'hFF, 8'h00};
  logic [7:0]  tb1 [5] = '{8'h21, 8'h42, 8'h7E, 8'hA1, 8'h00};

  assign settings = {halt_entry_reset_select, watchdog_type_select,
                     clock_source_select, half_clock_divider, reset_cycles,
                     low_voltage_detector, auxiliary_voltage_detector,
                     readout_protect, package_code, package_pins,
                     motor_output_reset_oe, motor_output_reset_level};

  initial begin
    forever #4 clk = ~clk;
  end

  option_byte_config_decoder option_byte_config_decoder_i (
    .clk(clk), .rst(rst), .store_init(store_init),
    .prog_mode(prog_mode), .prog_sel(prog_sel), .prog_wr(prog_wr),
    .prog_erase(prog_erase), .prog_wdata(prog_wdata),
    .prog_rdata(prog_rdata), .prog_busy(prog_busy),
    .user_erase_req(user_erase_req), .user_erase_done(user_erase_done),
    .user_mem_block(user_mem_block),
    .halt_entry_reset_select(halt_entry_reset_select),
    .watchdog_type_select(watchdog_type_select),
    .clock_source_select(clock_source_select),
    .half_clock_divider(half_clock_divider), .reset_cycles(reset_cycles),
    .low_voltage_detector(low_voltage_detector),
    .auxiliary_voltage_detector(auxiliary_voltage_detector),
    .readout_protect(readout_protect), .package_code(package_code),
    .package_pins(package_pins),
    .motor_output_reset_oe(motor_output_reset_oe),
    .motor_output_reset_level(motor_output_reset_level)
  );

  prog_tool_model prog_tool_model_i (
    .clk(clk), .prog_mode(prog_mode), .prog_sel(prog_sel),
    .prog_wr(prog_wr), .prog_erase(prog_erase), .prog_wdata(prog_wdata)
  );

  // Expected settings packed in the same order as the settings vector.
  function automatic logic [31:0] expect_cfg(input logic [7:0] b0, b1);
    logic [12:0] cyc;
    logic [6:0]  pins;
    logic        oe;
    cyc = (!b0[5] || !b0[2]) ? 13'h1000 : 13'h0100;
    case (b1[7:5])
      3'h0:    pins = option_cfg_pkg::PINS_32;
      3'h1:    pins = option_cfg_pkg::PINS_44;
      3'h2:    pins = option_cfg_pkg::PINS_56;
      3'h3:    pins = option_cfg_pkg::PINS_64;
      default: pins = option_cfg_pkg::PINS_80;
    endcase
    oe = b1[1] ^ b1[0];
    return {b0[7], b0[6], b0[5], ~b0[1], cyc,
            b0[4:3] != 2'h2 && b0[4:3] != 2'h3, b0[4:3] == 2'h0,
            ~b0[0], b1[7:5], pins, oe, b1[1] & ~b1[0]};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic reset_dut();
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    settle(3);
  endtask

  task automatic t_erased();
    cur_exp = expect_cfg(8'hFF, 8'hFF);
    check("erased settings", settings, cur_exp);
    check("busy", {31'h0, prog_busy}, 32'h0);
    prog_tool_model_i.write_byte(1'b0, 8'h00);
    settle(1);
    check("rdata out of mode", {24'h0, prog_rdata}, 32'h0);
    prog_tool_model_i.set_mode(1'b1);
    settle(2);
    check("refused write", {24'h0, prog_rdata}, 32'hFF);
    $display("test erased done");
  endtask

  task automatic t_load(input logic [7:0] b0, b1);
    prog_tool_model_i.set_mode(1'b1);
    prog_tool_model_i.write_byte(1'b0, b0);
    settle(1);
    check("byte0 readback", {24'h0, prog_rdata}, {24'h0, b0});
    prog_tool_model_i.write_byte(1'b1, b1);
    settle(1);
    check("byte1 readback", {24'h0, prog_rdata}, {24'h0, b1});
    check("settings held", settings, cur_exp);
    prog_tool_model_i.set_mode(1'b0);
    reset_dut();
    cur_exp = expect_cfg(b0, b1);
    check("loaded settings", settings, cur_exp);
    $display("test load %h %h done", b0, b1);
  endtask

  task automatic t_protect();
    prog_tool_model_i.set_mode(1'b1);
    settle(1);
    check("memory blocked", {31'h0, user_mem_block}, 32'h1);
    prog_tool_model_i.erase_opts();
    settle(1);
    check("erase request", {30'h0, user_erase_req, prog_busy}, 32'h3);
    prog_tool_model_i.write_byte(1'b1, 8'h55);
    settle(1);
    check("write while busy", {24'h0, prog_rdata}, 32'h0);
    check("still waiting", {31'h0, user_erase_req}, 32'h1);
    @(posedge clk);
    user_erase_done <= 1'b1;
    @(posedge clk);
    user_erase_done <= 1'b0;
    settle(3);
    check("erase finished", {30'h0, user_erase_req, prog_busy}, 32'h0);
    check("options erased", {24'h0, prog_rdata}, 32'hFF);
    prog_tool_model_i.set_mode(1'b0);
    reset_dut();
    check("erased reload", settings, expect_cfg(8'hFF, 8'hFF));
    // Unprotected store: the erase clears the options at once.
    prog_tool_model_i.set_mode(1'b1);
    prog_tool_model_i.write_byte(1'b1, 8'h55);
    settle(1);
    check("open byte1", {24'h0, prog_rdata}, 32'h55);
    check("memory open", {31'h0, user_mem_block}, 32'h0);
    prog_tool_model_i.erase_opts();
    settle(1);
    check("open erase", {22'h0, user_erase_req, prog_busy, prog_rdata},
          32'hFF);
    prog_tool_model_i.set_mode(1'b0);
    $display("test protect done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst        <= 1'b0;
    store_init <= 1'b0;
    settle(3);
    t_erased();
    prog_tool_model_i.set_mode(1'b0);
    for (int i = 0; i < 5; i++) begin
      t_load(i == 3 ? prog_tool_model_i.resonator_image(tb0[i]) : tb0[i],
             tb1[i]);
    end
    t_protect();
    close_out();
  end

  // The tests take well under 2000 cycles; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end
endmodule
